/* bench/sig_checker_assertions.sv */
// Port-level assertions for the signature capture and display block
`timescale 1ns/10ps
module sig_checker #(
  parameter GATE_CYC  = 20,
  parameter PHASE_CYC = 200
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        probe_hi,
  input wire        probe_reset,
  input wire [27:0] seg_r,
  input wire        seg_dim_r,
  input wire        gate_lamp_r,
  input wire        probe_bright_r,
  input wire        probe_dim_r
);
  int gate_cnt;
  int dim_cnt;
  // Blank is allowed only because the display may lag reset release
  function automatic bit legal(input [6:0] g);
    case (g)
      7'h00, 7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f,
      7'h77, 7'h39, 7'h71, 7'h76, 7'h73, 7'h3e: legal = 1;
      default: legal = 0;
    endcase
  endfunction
  always @(posedge aclk) begin
    gate_cnt <= (!aresetn || !gate_lamp_r) ? 0 : gate_cnt + 1;
    dim_cnt  <= (!aresetn || !seg_dim_r) ? 0 : dim_cnt + 1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rst_held;
    (probe_reset && !seg_dim_r) [*8];
  endsequence
  sequence bright_on;
    $rose(probe_bright_r);
  endsequence
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_probe_excl: assert property (!(probe_bright_r && probe_dim_r))
    else $error("probe lamp bright and dim together");
  chk_probe_rise: assert property ($rose(probe_hi) |-> ##[1:8] probe_bright_r)
    else $error("probe high not shown bright");
  chk_bright_stretch: assert property (bright_on |-> probe_bright_r [*8])
    else $error("bright indication not stretched");
  chk_dim_full: assert property (seg_dim_r |-> seg_r == 28'hfff_ffff)
    else $error("dim phase not all segments");
  chk_dim_span: assert property (dim_cnt <= PHASE_CYC + 1)
    else $error("dim phase too long");
  chk_glyph_legal: assert property (!seg_dim_r |-> legal(seg_r[27:21]) && legal(seg_r[20:14])
    && legal(seg_r[13:7]) && legal(seg_r[6:0]))
    else $error("illegal digit glyph");
  chk_gate_hold: assert property (gate_lamp_r && gate_cnt < GATE_CYC - 1 |=> gate_lamp_r)
    else $error("window lamp too short");
  chk_reset_zeros: assert property (rst_held |-> seg_r == {4{7'h3f}})
    else $error("probe reset did not show zeros");
endmodule // sig_checker
bind signature_capture_display sig_checker #(.GATE_CYC(GATE_CYC), .PHASE_CYC(PHASE_CYC)) sig_checker_i (.*);

/* bench/test_signature_capture_display.sv */
// Self-checking bench for the signature capture and display block
`timescale 1ns/10ps
module test_signature_capture_display;
  localparam [111:0] GLYPHS = {7'h3e, 7'h73, 7'h76, 7'h71, 7'h39, 7'h77, 7'h6f, 7'h7f,
                               7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
  logic        aclk = 0, aresetn = 0, probe_reset = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire         uut_clk, win_open, win_close, probe_hi, probe_lo;
  logic [27:0] seg_r;
  logic        seg_dim_r, gate_lamp_r, mismatch_lamp_r, probe_bright_r, probe_dim_r, irq_r;
  logic        tp_probe_r, tp_open_r, tp_close_r, tp_clk_r;
  logic [3:0]  tp_seen = 0;
  logic [63:0] bits;
  logic [15:0] sig, prev;
  int          fail_count = 0, check_count = 0, seed = 32'h11bd_f76f, i, k;
  signature_capture_display #(.STRETCH_CYC(40), .PHASE_CYC(200), .GATE_CYC(20)) signature_capture_display_i (.*);
  uut_model uut_model_i (.uut_clk(uut_clk), .win_open(win_open), .win_close(win_close), .probe_hi(probe_hi),
                         .probe_lo(probe_lo));
  always #12.5 aclk = ~aclk;
  // Each test point must be seen high at least once during self-test
  always @(posedge aclk) begin
    if (aresetn) tp_seen <= tp_seen | {tp_probe_r, tp_open_r, tp_close_r, tp_clk_r};
  end
  function automatic [15:0] sig_of(input [63:0] b, input int n);
    sig_of = 0;
    for (int j = 0; j < n; j++) sig_of = {sig_of[14:0], b[j] ^ sig_of[6] ^ sig_of[8] ^ sig_of[11] ^ sig_of[15]};
  endfunction
  function automatic [27:0] segs(input [15:0] s);
    segs = {GLYPHS[s[15:12]*7 +: 7], GLYPHS[s[11:8]*7 +: 7], GLYPHS[s[7:4]*7 +: 7], GLYPHS[s[3:0]*7 +: 7]};
  endfunction
  task cmp(input string name, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task axi_wr(input [3:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
    end while (s_axi_bvalid !== 1 && n < 50);
    s_axi_bready <= 0;
    cmp("bresp", 4, {s_axi_bvalid, s_axi_bresp});
  endtask
  task axi_rd(input [3:0] a, output [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
    end while (s_axi_rvalid !== 1 && n < 50);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    cmp("rresp", 4, {s_axi_rvalid, s_axi_rresp});
  endtask
  // Gate lamp is skipped for windows that freeze mode ignores
  task win(input [63:0] b, input int n, input bit [1:0] mode, input [15:0] shown, input bit lamp);
    uut_model_i.frame(b, n, mode);
    repeat (10) @(posedge aclk);
    axi_rd(4'h4, rd);
    cmp("signature", shown, rd[15:0]);
    cmp("segments", segs(shown), seg_r);
    if (lamp) cmp("gate_lamp", 1, gate_lamp_r);
  endtask
  task wait_dim(input bit v);
    for (int n = 0; n < 1000 && seg_dim_r !== v; n++) @(posedge aclk);
  endtask
  initial begin
    #1_000_000;
    fail_count++;
    $display("FAIL watchdog expected finish seen timeout");
    close_out;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    axi_rd(4'h0, rd);
    cmp("ctrl_reset", 32'h0000_0007, rd);
    axi_rd(4'h4, rd);
    cmp("status_reset", 0, rd);
    cmp("tp_idle", 0, {tp_probe_r, tp_open_r, tp_close_r, tp_clk_r});
    axi_wr(4'hc, 3);
    win(1, 1, 0, 16'h0001, 1);
    cmp("mismatch_first", 1, mismatch_lamp_r);
    cmp("irq_raised", 1, irq_r);
    axi_wr(4'h8, 3);
    repeat (3) @(posedge aclk);
    cmp("irq_cleared", 0, irq_r);
    $display("test one_bit_window done");
    for (k = 0; k < 3; k++) begin
      axi_wr(4'hc, k == 2 ? 2 : 3);
      prev = k ? sig : 16'h0001;
      i = 16 + ($random(seed) & 15);
      bits = {$random(seed), $random(seed)};
      sig = sig_of(bits, i);
      win(bits, i, 0, sig, 1);
      cmp("mismatch_new", sig != prev, mismatch_lamp_r);
      axi_wr(4'h8, 3);
      win(bits, i, 0, sig, 1);
      cmp("mismatch_same", 0, mismatch_lamp_r);
      axi_rd(4'h8, rd);
      cmp("irq_stat", 1, rd);
      cmp("irq_masked", k != 2, irq_r);
    end
    $display("test random_windows done");
    axi_wr(4'h0, 32'h0000_0005);
    bits = {$random(seed), $random(seed)};
    win(bits, 20, 1, sig_of(bits, 20), 1);
    $display("test single_pulse done");
    // Falling clock edge and falling open edge, close still rising
    axi_wr(4'h0, 32'h0000_0002);
    bits = {$random(seed), $random(seed)};
    win(bits, 20, 2, sig_of(bits, 20), 1);
    $display("test falling_edges done");
    axi_wr(4'h0, 32'h0000_000f);
    bits = {$random(seed), $random(seed)};
    sig = sig_of(bits, 24);
    win(bits, 24, 0, sig, 1);
    cmp("held", 1, rd[18]);
    win(~bits, 24, 0, sig, 0);
    probe_reset <= 1;
    repeat (12) @(posedge aclk);
    probe_reset <= 0;
    axi_rd(4'h4, rd);
    cmp("cleared", 0, {rd[18], rd[15:0]});
    cmp("seg_zero", segs(0), seg_r);
    win(~bits, 24, 0, sig_of(~bits, 24), 1);
    axi_wr(4'h0, 32'h0000_0007);
    $display("test freeze done");
    uut_model_i.set_probe(0, 1);
    repeat (60) @(posedge aclk);
    uut_model_i.set_probe(1, 0);
    repeat (4) @(posedge aclk);
    uut_model_i.set_probe(0, 1);
    repeat (20) @(posedge aclk);
    cmp("stretched", 2, {probe_bright_r, probe_dim_r});
    repeat (60) @(posedge aclk);
    cmp("lamp_off", 0, {probe_bright_r, probe_dim_r});
    uut_model_i.set_probe(0, 0);
    repeat (60) @(posedge aclk);
    cmp("lamp_dim", 1, {probe_bright_r, probe_dim_r});
    $display("test probe_lamp done");
    axi_wr(4'h0, 32'h0000_0017);
    for (k = 0; k < 3; k++) begin
      if (k == 1) axi_wr(4'h0, 32'h0000_0011);
      wait_dim(1);
      cmp("dim_lit", 28'hfff_ffff, seg_r);
      wait_dim(0);
      if (k == 2) probe_reset <= 1;
      repeat (50) @(posedge aclk);
      cmp("first_sig", k == 2 ? segs(0) : k ? segs(16'h3951) : segs(16'hfe73), seg_r);
      repeat (100) @(posedge aclk);
      cmp("second_sig", k == 2 ? segs(0) : k ? segs(16'h2e61) : segs(16'haba2), seg_r);
    end
    wait_dim(1);
    cmp("dim_in_reset", 28'hfff_ffff, seg_r);
    probe_reset <= 0;
    axi_wr(4'h0, 32'h0000_0007);
    repeat (4) @(posedge aclk);
    cmp("tp_moved", 4'hf, tp_seen);
    cmp("tp_quiet", 0, {tp_probe_r, tp_open_r, tp_close_r, tp_clk_r});
    $display("test self_test done");
    close_out;
  end
endmodule // test_signature_capture_display

/* bench/uut_model.sv */
// Unit-under-test side: gated serial frames on a stopping link clock
`timescale 1ns/10ps
module uut_model (
  output reg uut_clk,
  output reg win_open,
  output reg win_close,
  output reg probe_hi,
  output reg probe_lo
);
  initial begin
    uut_clk = 0;
    win_open = 0;
    win_close = 0;
    probe_hi = 0;
    probe_lo = 1;
  end
  // Idle first edge lets the open pin be seen at rest before it moves
  // Levels change 50 ns clear of both clock edges, so either edge select sees stable data
  // Mode bit 0: one pulse on both window pins; bit 1: open pin idles high and opens falling
  task frame(input [63:0] bits, input int n, input bit [1:0] mode);
    int i;
    #7;
    for (i = 0; i <= n; i++) begin
      win_open = mode[1] ^ (mode[0] ? (i > 0 && i < n) : (i > 0));
      win_close = mode[0] ? (i > 0 && i < n) : (i == n);
      probe_hi = i > 0 && bits[i-1];
      probe_lo = !probe_hi;
      #50 uut_clk = 1;
      #100 uut_clk = 0;
      #50;
    end
    win_open = mode[1];
    win_close = 0;
  endtask
  task set_probe(input bit hi, input bit lo);
    #7;
    probe_hi = hi;
    probe_lo = lo;
  endtask
endmodule // uut_model

/* src/hex_glyph.v */
// Hex digit to seven-segment glyph decoder with the unambiguous letter set
`timescale 1ns/10ps
module hex_glyph (
  input  wire [3:0] digit,
  output reg  [6:0] seg
);
  // Segments gfedcba, high lights the segment
  always @* begin
    case (digit)
      4'h0:    seg = 7'h3f;
      4'h1:    seg = 7'h06;
      4'h2:    seg = 7'h5b;
      4'h3:    seg = 7'h4f;
      4'h4:    seg = 7'h66;
      4'h5:    seg = 7'h6d;
      4'h6:    seg = 7'h7d;
      4'h7:    seg = 7'h07;
      4'h8:    seg = 7'h7f;
      4'h9:    seg = 7'h6f;
      4'ha:    seg = 7'h77; // A
      4'hb:    seg = 7'h39; // C in place of b
      4'hc:    seg = 7'h71; // F
      4'hd:    seg = 7'h76; // H in place of d
      4'he:    seg = 7'h73; // P
      default: seg = 7'h3e; // U
    endcase
  end
endmodule // hex_glyph

/* src/sig_consts.vh */
// Register map, field positions, reset values and timing constants
`ifndef SIG_CONSTS_VH
`define SIG_CONSTS_VH

`define SIG_ADDR_W        4
`define SIG_CTRL_OFS      4'h0
`define SIG_STAT_OFS      4'h4
`define SIG_IRQ_STAT_OFS  4'h8
`define SIG_IRQ_MASK_OFS  4'hc

`define SIG_CTRL_CLK_RISE   0
`define SIG_CTRL_STOP_RISE  1
`define SIG_CTRL_START_RISE 2
`define SIG_CTRL_HOLD       3
`define SIG_CTRL_SELFTEST   4
`define SIG_CTRL_W          5
`define SIG_CTRL_RESET      5'h07

`define SIG_STAT_GATE     16
`define SIG_STAT_MISMATCH 17
`define SIG_STAT_HELD     18
`define SIG_STAT_OPEN     19

`define SIG_IRQ_WINDOW    0
`define SIG_IRQ_MISMATCH  1
`define SIG_IRQ_W         2

`define SIG_RESP_OKAY     2'h0
`define SIG_RESP_DECERR   2'h3

`define SIG_CLK_HZ        40000000
`define SIG_STRETCH_MS    100
`define SIG_STRETCH_CYC   (`SIG_CLK_HZ / 1000 * `SIG_STRETCH_MS)
`define SIG_PHASE_S       1
`define SIG_PHASE_CYC     (`SIG_CLK_HZ * `SIG_PHASE_S)
`define SIG_GATE_MS       50
`define SIG_GATE_CYC      (`SIG_CLK_HZ / 1000 * `SIG_GATE_MS)
`define SIG_STIM_DIV      20

`define SIG_ST_UP73       16'hfe73
`define SIG_ST_ACA2       16'haba2
`define SIG_ST_3951       16'h3951
`define SIG_ST_2P61       16'h2e61
`define SIG_CNT_W         26

`endif

/* src/signature_capture_display.v */
// Signature capture, compaction and display control with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "sig_consts.vh"
// Notes on behaviour
// - Each signature is shown as four seven-segment digits, each one of 16 symbols.
// - The display shows the hex residue of the compaction count formed between an open and a close event.
// - Digits ten to fifteen use the glyphs A, C, F, H, P, U so none looks like eight or zero.
// - The unit under test gives repeating open and close events and data is taken only inside that window.
// - The window lamp flashes on every completed open-and-close window.
// - The mismatch lamp lights whenever two successive signatures differ.
// - The probe lamp is bright for high, dim for an invalid level, off for low, and pulses stretch to 100 ms.
// - Clock, close and open inputs each have their own rising or falling edge select.
// - With open set to rising and close to falling, one pulse on both window inputs opens on its rising edge and closes on its falling edge.
// - In freeze mode one signature is captured and kept, later windows are ignored.
// - The probe reset erases a frozen signature so a new single capture can follow.
// - Self-test drives stimulus onto test points for probe, open, close and clock.
// - Self-test alternates a dim all-segment phase and a signature phase of about one second each.
// - Probe reset during self-test shows zeros in the signature phase, the dim phase stays.
module signature_capture_display #(
  parameter STRETCH_CYC = `SIG_STRETCH_CYC,
  parameter PHASE_CYC   = `SIG_PHASE_CYC,
  parameter GATE_CYC    = `SIG_GATE_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        uut_clk,
  input  wire        win_open,
  input  wire        win_close,
  input  wire        probe_hi,
  input  wire        probe_lo,
  input  wire        probe_reset,
  output reg  [27:0] seg_r,
  output reg         seg_dim_r,
  output reg         gate_lamp_r,
  output reg         mismatch_lamp_r,
  output reg         probe_bright_r,
  output reg         probe_dim_r,
  output reg         tp_probe_r,
  output reg         tp_open_r,
  output reg         tp_close_r,
  output reg         tp_clk_r,
  output reg         irq_r
);
  localparam CW = `SIG_CNT_W;

  // Two-flop synchronisers; stage one feeds stage two only
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg       uclk_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r  <= 6'h00;
      sync2_r  <= 6'h00;
      uclk_d_r <= 1'b0;
    end else begin
      sync1_r  <= {uut_clk, win_open, win_close, probe_hi, probe_lo, probe_reset};
      sync2_r  <= sync1_r;
      uclk_d_r <= sync2_r[5];
    end
  end
  wire uclk_s  = sync2_r[5];
  wire open_s  = sync2_r[4];
  wire close_s = sync2_r[3];
  wire hi_s    = sync2_r[2];
  wire lo_s    = sync2_r[1];
  wire prst_s  = sync2_r[0];

  reg [`SIG_CTRL_W-1:0] ctrl_r;
  reg [`SIG_IRQ_W-1:0]  irq_stat_r;
  reg [`SIG_IRQ_W-1:0]  irq_mask_r;
  wire sel_clk   = ctrl_r[`SIG_CTRL_CLK_RISE];
  wire sel_close = ctrl_r[`SIG_CTRL_STOP_RISE];
  wire sel_open  = ctrl_r[`SIG_CTRL_START_RISE];
  wire hold      = ctrl_r[`SIG_CTRL_HOLD];
  wire selftest  = ctrl_r[`SIG_CTRL_SELFTEST];

  // Active edge of the unit-under-test clock
  wire uclk_edge = sel_clk ? (uclk_s & ~uclk_d_r) : (~uclk_s & uclk_d_r);

  // Window inputs are judged only at active clock edges, so setup is measured to that edge
  reg        open_prev_r;
  reg        close_prev_r;
  reg        win_r;
  reg [15:0] comp_r;
  reg [15:0] disp_sig_r;
  reg        held_r;
  reg        sig_new_r;
  reg        sig_diff_r;
  wire open_evt  = uclk_edge & (open_s != open_prev_r) & (open_s == sel_open);
  wire close_evt = uclk_edge & (close_s != close_prev_r) & (close_s == sel_close);
  wire in_win    = win_r | open_evt;
  wire [15:0] comp_base = open_evt ? 16'h0000 : comp_r;
  wire        comp_fb   = hi_s ^ comp_base[6] ^ comp_base[8] ^ comp_base[11] ^ comp_base[15];
  wire [15:0] comp_nxt  = {comp_base[14:0], comp_fb};
  wire        take      = close_evt & in_win & ~(hold & held_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      open_prev_r  <= 1'b0;
      close_prev_r <= 1'b0;
      win_r        <= 1'b0;
      comp_r       <= 16'h0000;
      disp_sig_r   <= 16'h0000;
      held_r       <= 1'b0;
      sig_new_r    <= 1'b0;
      sig_diff_r   <= 1'b0;
    end else begin
      sig_new_r <= take;
      if (uclk_edge) begin
        open_prev_r  <= open_s;
        close_prev_r <= close_s;
        if (in_win)
          comp_r <= comp_nxt;
        if (close_evt & in_win)
          win_r <= 1'b0;
        else if (open_evt)
          win_r <= 1'b1;
      end
      if (take) begin
        disp_sig_r <= comp_nxt;
        sig_diff_r <= (comp_nxt != disp_sig_r);
        held_r     <= hold;
      end else if (prst_s & held_r) begin
        disp_sig_r <= 16'h0000;
        held_r     <= 1'b0;
      end
      if (!hold)
        held_r <= 1'b0;
    end
  end

  // Self-test phase timer and stimulus divider
  reg [CW-1:0] phase_cnt_r;
  reg          phase_sig_r;
  reg [4:0]    div_cnt_r;
  reg [7:0]    stim_r;
  wire stim_en = (div_cnt_r == 5'd0);
  always @(posedge aclk) begin
    if (!aresetn || !selftest) begin
      phase_cnt_r <= {CW{1'b0}};
      phase_sig_r <= 1'b0;
      div_cnt_r   <= 5'd0;
      stim_r      <= 8'h00;
    end else begin
      div_cnt_r <= (div_cnt_r == 5'd`SIG_STIM_DIV - 5'd1) ? 5'd0 : div_cnt_r + 5'd1;
      if (stim_en)
        stim_r <= stim_r + 8'h01;
      if (phase_cnt_r == PHASE_CYC[CW-1:0] - 1'b1) begin
        phase_cnt_r <= {CW{1'b0}};
        phase_sig_r <= ~phase_sig_r;
      end else
        phase_cnt_r <= phase_cnt_r + 1'b1;
    end
  end

  wire both_sel = sel_open & sel_close;
  wire second   = (phase_cnt_r >= PHASE_CYC[CW-1:0] / 2);
  reg [15:0] shown;
  always @* begin
    if (!selftest)
      shown = disp_sig_r;
    else if (prst_s)
      shown = 16'h0000;
    else if (both_sel)
      shown = second ? `SIG_ST_ACA2 : `SIG_ST_UP73;
    else
      shown = second ? `SIG_ST_2P61 : `SIG_ST_3951;
  end

  wire [27:0] glyphs;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dig
      hex_glyph u_glyph (
        .digit (shown[gi*4 +: 4]),
        .seg   (glyphs[gi*7 +: 7])
      );
    end
  endgenerate

  // Lamp stretchers
  reg [CW-1:0] gate_cnt_r;
  reg [CW-1:0] hi_cnt_r;
  reg [CW-1:0] lo_cnt_r;
  reg          hi_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_r <= {CW{1'b0}};
      hi_cnt_r   <= {CW{1'b0}};
      lo_cnt_r   <= {CW{1'b0}};
      hi_d_r     <= 1'b0;
    end else begin
      hi_d_r <= hi_s;
      if (close_evt & in_win)
        gate_cnt_r <= GATE_CYC[CW-1:0];
      else if (gate_cnt_r != {CW{1'b0}})
        gate_cnt_r <= gate_cnt_r - 1'b1;
      if (hi_s & ~hi_d_r)
        hi_cnt_r <= STRETCH_CYC[CW-1:0];
      else if (hi_cnt_r != {CW{1'b0}})
        hi_cnt_r <= hi_cnt_r - 1'b1;
      if (~hi_s & hi_d_r)
        lo_cnt_r <= STRETCH_CYC[CW-1:0];
      else if (lo_cnt_r != {CW{1'b0}})
        lo_cnt_r <= lo_cnt_r - 1'b1;
    end
  end
  wire hi_str = (hi_cnt_r != {CW{1'b0}});
  wire lo_str = (lo_cnt_r != {CW{1'b0}});

  // Registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      seg_r           <= 28'h000_0000;
      seg_dim_r       <= 1'b0;
      gate_lamp_r     <= 1'b0;
      mismatch_lamp_r <= 1'b0;
      probe_bright_r  <= 1'b0;
      probe_dim_r     <= 1'b0;
      tp_probe_r      <= 1'b0;
      tp_open_r       <= 1'b0;
      tp_close_r      <= 1'b0;
      tp_clk_r        <= 1'b0;
    end else begin
      seg_r           <= (selftest & ~phase_sig_r) ? 28'hfff_ffff : glyphs;
      seg_dim_r       <= selftest & ~phase_sig_r;
      gate_lamp_r     <= (gate_cnt_r != {CW{1'b0}});
      mismatch_lamp_r <= sig_diff_r;
      probe_bright_r  <= hi_str | (hi_s & ~lo_str);
      probe_dim_r     <= ~hi_s & ~lo_s & ~hi_str & ~lo_str;
      // Window spans one eighth of the stimulus period; clock toggles every step
      tp_clk_r        <= selftest & stim_r[0];
      tp_open_r       <= selftest & (stim_r[7:5] == 3'h1);
      tp_close_r      <= selftest & (stim_r[7:5] == 3'h1);
      tp_probe_r      <= selftest & (stim_r[2] ^ stim_r[4] ^ stim_r[6]);
    end
  end

  // AXI4-Lite slave, one write and one read in flight
  reg        aw_got_r;
  reg        w_got_r;
  reg [3:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  wire do_wr     = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_ctrl   = do_wr & (aw_addr_r == `SIG_CTRL_OFS) & w_strb_r[0];
  wire wr_istat  = do_wr & (aw_addr_r == `SIG_IRQ_STAT_OFS) & w_strb_r[0];
  wire wr_imask  = do_wr & (aw_addr_r == `SIG_IRQ_MASK_OFS) & w_strb_r[0];
  wire wr_mapped = (aw_addr_r == `SIG_CTRL_OFS) | (aw_addr_r == `SIG_STAT_OFS) |
                   (aw_addr_r == `SIG_IRQ_STAT_OFS) | (aw_addr_r == `SIG_IRQ_MASK_OFS);
  wire [`SIG_IRQ_W-1:0] irq_set = {sig_new_r & sig_diff_r, sig_new_r};
  wire [`SIG_IRQ_W-1:0] irq_clr = wr_istat ? w_data_r[`SIG_IRQ_W-1:0] : {`SIG_IRQ_W{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SIG_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 4'h0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      ctrl_r        <= `SIG_CTRL_RESET;
      irq_stat_r    <= {`SIG_IRQ_W{1'b0}};
      irq_mask_r    <= {`SIG_IRQ_W{1'b0}};
      irq_r         <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= {s_axi_awaddr[3:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `SIG_RESP_OKAY : `SIG_RESP_DECERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (wr_ctrl)
        ctrl_r <= w_data_r[`SIG_CTRL_W-1:0];
      if (wr_imask)
        irq_mask_r <= w_data_r[`SIG_IRQ_W-1:0];
      // Hardware set beats a same-cycle write-one clear
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  wire [3:0] ra = {s_axi_araddr[3:2], 2'b00};
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SIG_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SIG_RESP_OKAY;
      case (ra)
        `SIG_CTRL_OFS:     s_axi_rdata <= {27'h000_0000, ctrl_r};
        `SIG_STAT_OFS:     s_axi_rdata <= {12'h000, win_r, held_r, mismatch_lamp_r, gate_lamp_r, disp_sig_r};
        `SIG_IRQ_STAT_OFS: s_axi_rdata <= {30'h0000_0000, irq_stat_r};
        `SIG_IRQ_MASK_OFS: s_axi_rdata <= {30'h0000_0000, irq_mask_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SIG_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // signature_capture_display
